// File: design/cgs_top.sv
//Behaviour
//- internal osc mode register resets 00H; one halt bit, 1 requests stop.
//- internal osc never stops while CPU runs on it.
//- after watchdog overflow in stabilization, osc keeps running; halt bit reads 1.
//- halt bit has effect only when option configuration permits.
//- read-only status flag is 1 when CPU runs on internal osc.
//- status resets 00H; watchdog overflow in stabilization makes it 01H.
//- main osc and main watch timer clock gating per mode table.
//- main system, peripheral, watchdog main clocks run only in HALT/run.
//- internal system clock runs in HALT/run; CPU clock stops in HALT.
//- multiplier starts at half stabilization, stable after lockup.
//- multiplied clock runs in light idle, stops deep idle and STOP.
//- subclock always runs; watchdog internal clock runs except in reset.
//- clock pin carries internal system clock at divider-selected rate.
//- clock pin holds low while internal system clock is stopped.
//- after reset the clock pin is high-impedance port input.
//- clock pin drives only when port config selects clock output.
//- multiplier mode gives four times the oscillator input.
//- clock-through mode passes oscillator frequency unchanged.
//- divider code picks fxx/2..64 or subclock; 0110, 0111 prohibited.
//- subclock status reads 1 while CPU clock is subclock.
//- main osc stop bit takes effect only once CPU is on subclock.
//- processor clock write accepted only right after protect command.
`timescale 1ns/100ps
`default_nettype none
module cgs_top #(
  parameter logic [15:0] STAB_CYC = cgs_pkg::STAB_CYC_DEF, // stabilization
  parameter logic [15:0] LOCK_CYC = cgs_pkg::LOCK_CYC_DEF  // multiplier lockup
) (
  input  wire logic              CLK_I,              // fxx, 250 MHz
  input  wire logic              RST_I,              // async reset, high
  input  wire logic [7:0]        ADDR_I,             // register address
  input  wire logic [7:0]        WDATA_I,            // write data
  input  wire logic              WR_I,               // write strobe
  input  wire logic              RD_I,               // read strobe
  output logic      [7:0]        RDATA_O,            // read data, next cycle
  input  wire cgs_pkg::cgs_mode_t MODE_I,            // standby mode request
  input  wire logic              WDT_OVF_I,          // watchdog overflow
  input  wire logic              OPT_INT_OSC_CTRL_I, // option permits halt
  input  wire logic              MULT_SEL_I,         // multiplier select
  input  wire logic              PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I,  // port picks clock out
  input  wire logic              SUB_CLK_I,          // subclock pin
  output logic                   MAIN_OSC_RUN_O,     // main oscillator on
  output logic                   MAIN_SYS_RUN_O,     // fxx enabled
  output logic                   PERIPH_RUN_O,       // prescaled clocks on
  output logic                   WDT_MAIN_RUN_O,     // watchdog main clock
  output logic                   WT_MAIN_RUN_O,      // watch timer main clk
  output logic                   WT_SUB_RUN_O,       // watch timer sub clk
  output logic                   SYS_CLK_RUN_O,      // internal system clk
  output logic                   CPU_CLK_RUN_O,      // CPU clock
  output logic                   PLL_RUN_O,          // multiplier running
  output logic                   PLL_STABLE_O,       // multiplier locked
  output logic                   MULT_X4_O,          // x4 clock selected
  output logic                   SUB_OSC_RUN_O,      // subclock oscillator
  output logic                   WDT_INT_RUN_O,      // watchdog int clock
  output logic                   INT_OSC_RUN_O,      // internal oscillator
  output logic                   CPU_ON_INT_O,       // CPU on internal osc
  output logic                   SYSTEM_CLOCK_OUTPUT_PIN_O,           // clock pin level
  output logic                   SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O       // clock pin enable, low
);
  import cgs_pkg::*;

  cgs_state_t       state_r;
  cgs_state_t       state_nxt;
  logic [CNT_W-1:0] stab_cnt_r;
  logic [CNT_W-1:0] lock_cnt_r;
  logic             armed_r;
  logic             frc_r;
  logic             mck_r;
  logic             mfrc_r;
  logic [3:0]       ck_r;
  logic             rcm_halt_r;
  logic             cpu_clock_source_state_r;
  logic             sub_s1_r;
  logic             sub_s2_r;
  logic             cpu_on_subclock_flag;
  logic             clk_div;
  logic [7:0]       rdata_r;
  logic             main_osc_r;
  logic             main_sys_r;
  logic             wt_main_r;
  logic             sys_r;
  logic             cpu_r;
  logic             pll_r;
  logic             pll_stable_r;
  logic             mult_r;
  logic             sub_r;
  logic             wdt_int_r;
  logic             int_osc_r;
  logic             oe_n_r;

  // register port decode
  wire hit_pcc  = ADDR_I == ADDR_PROC_CLK;
  wire hit_prot = ADDR_I == ADDR_PROTECT;
  wire hit_rcm  = ADDR_I == ADDR_INT_OSC_MODE;
  wire hit_cpu_clock_source_state = ADDR_I == ADDR_CPU_SRC_STATE;
  wire wr_pcc   = WR_I && hit_pcc;
  wire wr_prot  = WR_I && hit_prot;
  wire wr_rcm   = WR_I && hit_rcm;

  // mode decode; standby requests have no meaning while stabilizing
  wire stab     = state_r == CGS_ST_STAB;
  wire m_run    = MODE_I == CGS_MODE_RUN;
  wire m_halt   = MODE_I == CGS_MODE_HALT;
  wire m_deep_idle_mode  = MODE_I == CGS_MODE_DEEP_IDLE_MODE;
  wire m_stop   = MODE_I == CGS_MODE_STOP;

  wire osc_en   = !(mck_r && cpu_on_subclock_flag);

  wire main_osc_nxt = !stab ? (!m_stop && osc_en) : 1'b1;
  wire wt_main_nxt  = main_osc_nxt && !stab;
  wire sys_nxt      = !stab && (m_run || m_halt);
  wire cpu_nxt      = sys_nxt && m_run;
  wire main_sys_nxt = sys_nxt && osc_en;

  wire half_done = stab_cnt_r >= (STAB_CYC >> 1);
  wire pll_nxt   = stab ? half_done : (osc_en && !m_deep_idle_mode && !m_stop);
  wire lock_done = lock_cnt_r >= LOCK_CYC;

  wire halt_req = rcm_halt_r && OPT_INT_OSC_CTRL_I;
  wire int_osc_nxt = !(halt_req && !cpu_clock_source_state_r);

  wire       ck_bad = cgs_ck_bad(WDATA_I[PCC_CK_MSB:0]);
  wire [3:0] ck_nxt = ck_bad ? ck_r : WDATA_I[PCC_CK_MSB:0];

  // read multiplexer; unmapped and write-only addresses read zero
  wire [7:0] pcc_rd  = {frc_r, mck_r, mfrc_r, cpu_on_subclock_flag, ck_r};
  wire [7:0] rcm_rd  = {7'h00, rcm_halt_r};
  wire [7:0] cpu_clock_source_state_rd = {7'h00, cpu_clock_source_state_r};
  wire [7:0] rd_mux  = hit_pcc  ? pcc_rd :
                       hit_rcm  ? rcm_rd :
                       hit_cpu_clock_source_state ? cpu_clock_source_state_rd : 8'h00;

  // sequencer: stabilization runs once after reset release
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CGS_ST_STAB: begin
        if (stab_cnt_r >= STAB_CYC) begin
          state_nxt = CGS_ST_RUN;
        end
      end
      CGS_ST_RUN: begin
        state_nxt = CGS_ST_RUN;
      end
      default: begin
        state_nxt = CGS_ST_STAB;
      end
    endcase
  end

  // sequencer state and stabilization counter
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_r    <= CGS_ST_STAB;
      stab_cnt_r <= '0;
    end else begin
      state_r    <= state_nxt;
      stab_cnt_r <= stab ? stab_cnt_r + 16'd1 : '0;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      lock_cnt_r <= '0;
    end else if (!pll_r) begin
      lock_cnt_r <= '0;
    end else if (!lock_done) begin
      lock_cnt_r <= lock_cnt_r + 16'd1;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      armed_r <= 1'b0;
    end else if (WR_I) begin
      armed_r <= hit_prot;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      frc_r  <= PROC_CLK_RST[PCC_FRC_BIT];
      mck_r  <= PROC_CLK_RST[PCC_MCK_BIT];
      mfrc_r <= PROC_CLK_RST[PCC_MFRC_BIT];
      ck_r   <= PROC_CLK_RST[PCC_CK_MSB:0];
    end else if (wr_pcc && armed_r) begin
      frc_r  <= WDATA_I[PCC_FRC_BIT];
      mck_r  <= WDATA_I[PCC_MCK_BIT];
      mfrc_r <= WDATA_I[PCC_MFRC_BIT];
      ck_r   <= ck_nxt;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rcm_halt_r <= INT_OSC_MODE_RST[RCM_HALT_BIT];
    end else if (wr_rcm) begin
      rcm_halt_r <= WDATA_I[RCM_HALT_BIT];
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cpu_clock_source_state_r <= CPU_SRC_RST[CPU_CLOCK_SOURCE_STATE_FLAG_BIT];
    end else if (stab && WDT_OVF_I) begin
      cpu_clock_source_state_r <= 1'b1;
    end
  end

  // subclock pin synchroniser; only the second stage is looked at
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
    end else begin
      sub_s1_r <= SUB_CLK_I;
      sub_s2_r <= sub_s1_r;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= RD_I ? rd_mux : 8'h00;
    end
  end

  // clock enables to the gating cells, all registered
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      main_osc_r <= 1'b0;
      wt_main_r  <= 1'b0;
      main_sys_r <= 1'b0;
      sys_r      <= 1'b0;
      cpu_r      <= 1'b0;
    end else begin
      main_osc_r <= main_osc_nxt;
      wt_main_r  <= wt_main_nxt;
      main_sys_r <= main_sys_nxt;
      sys_r      <= sys_nxt;
      cpu_r      <= cpu_nxt;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pll_r        <= 1'b0;
      pll_stable_r <= 1'b0;
      mult_r       <= 1'b0;
    end else begin
      pll_r        <= pll_nxt;
      pll_stable_r <= pll_r && lock_done;
      mult_r       <= MULT_SEL_I && pll_r && lock_done;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sub_r     <= 1'b1;
      wdt_int_r <= 1'b0;
      int_osc_r <= 1'b1;
    end else begin
      sub_r     <= 1'b1;
      wdt_int_r <= 1'b1;
      int_osc_r <= int_osc_nxt;
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I;
    end
  end

  cgs_clk_div u_div (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .run_i     (sys_r),
    .sel_i     (ck_r),
    .sub_lvl_i (sub_s2_r),
    .clk_o     (clk_div),
    .on_sub_o  (cpu_on_subclock_flag)
  );

  assign RDATA_O        = rdata_r;
  assign MAIN_OSC_RUN_O = main_osc_r;
  assign MAIN_SYS_RUN_O = main_sys_r;
  assign PERIPH_RUN_O   = main_sys_r;
  assign WDT_MAIN_RUN_O = main_sys_r;
  assign WT_MAIN_RUN_O  = wt_main_r;
  assign WT_SUB_RUN_O   = sub_r;
  assign SYS_CLK_RUN_O  = sys_r;
  assign CPU_CLK_RUN_O  = cpu_r;
  assign PLL_RUN_O      = pll_r;
  assign PLL_STABLE_O   = pll_stable_r;
  assign MULT_X4_O      = mult_r;
  assign SUB_OSC_RUN_O  = sub_r;
  assign WDT_INT_RUN_O  = wdt_int_r;
  assign INT_OSC_RUN_O  = int_osc_r;
  assign CPU_ON_INT_O   = cpu_clock_source_state_r;
  assign SYSTEM_CLOCK_OUTPUT_PIN_O       = clk_div;
  assign SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O  = oe_n_r;

  // checks on the design's own registers and outputs
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_unlock;
    WR_I && hit_prot;
  endsequence
  sequence s_pcc_write;
    WR_I && hit_pcc && armed_r && !ck_bad;
  endsequence

  // a protect write arms the next write, reads in between allowed
  property p_unlock_arms;
    s_unlock |=> armed_r;
  endproperty
  a_unlock_arms: assert property (p_unlock_arms)
    else $error("protect write did not arm clock control");

  property p_guarded_write;
    s_pcc_write |=> ck_r == $past(WDATA_I[3:0]);
  endproperty
  a_guarded_write: assert property (p_guarded_write)
    else $error("protected write not taken");

  property p_unguarded_write;
    (wr_pcc && !armed_r) |=> $stable(mck_r) && $stable(ck_r);
  endproperty
  a_unguarded_write: assert property (p_unguarded_write)
    else $error("unprotected write changed clock control");

  property p_osc_held;
    cpu_clock_source_state_r |=> INT_OSC_RUN_O;
  endproperty
  a_osc_held: assert property (p_osc_held)
    else $error("internal osc stopped while cpu on it");

  property p_no_permit;
    !OPT_INT_OSC_CTRL_I |=> INT_OSC_RUN_O;
  endproperty
  a_no_permit: assert property (p_no_permit)
    else $error("halt bit honoured without permission");

  property p_flag_set;
    (stab && WDT_OVF_I) |=> CPU_ON_INT_O ##1 CPU_ON_INT_O;
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("source flag not set by watchdog overflow");

  property p_cpu_halt;
    (!stab && m_halt) |=> !CPU_CLK_RUN_O && SYS_CLK_RUN_O;
  endproperty
  a_cpu_halt: assert property (p_cpu_halt)
    else $error("cpu clock wrong in halt");

  property p_periph_idle;
    (!stab && !m_run && !m_halt) |=> !MAIN_SYS_RUN_O && !PERIPH_RUN_O;
  endproperty
  a_periph_idle: assert property (p_periph_idle)
    else $error("peripheral clock running in idle or stop");

  property p_pll_half;
    (stab && !half_done) |=> !PLL_RUN_O;
  endproperty
  a_pll_half: assert property (p_pll_half)
    else $error("multiplier started before half time");

  property p_pll_stop;
    (!stab && (m_stop || m_deep_idle_mode)) |=> !PLL_RUN_O ##1 !PLL_STABLE_O;
  endproperty
  a_pll_stop: assert property (p_pll_stop)
    else $error("multiplier running in deep idle or stop");

  property p_pin_low;
    (!SYS_CLK_RUN_O && !SYSTEM_CLOCK_OUTPUT_PIN_O) |=> !SYSTEM_CLOCK_OUTPUT_PIN_O;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("clock pin rose while system clock stopped");

  property p_mck_main;
    (!stab && !cpu_on_subclock_flag && !m_stop) |=> MAIN_OSC_RUN_O;
  endproperty
  a_mck_main: assert property (p_mck_main)
    else $error("main osc stopped while cpu on main clock");

  property p_sub_on;
    SUB_OSC_RUN_O && WT_SUB_RUN_O;
  endproperty
  a_sub_on: assert property (p_sub_on)
    else $error("subclock stopped");

endmodule
`default_nettype wire

// File: design/cgs_pkg.sv
package cgs_pkg;

  // register byte addresses on the plain register port
  localparam logic [7:0] ADDR_PROC_CLK      = 8'h00;
  localparam logic [7:0] ADDR_PROTECT       = 8'h04;
  localparam logic [7:0] ADDR_INT_OSC_MODE  = 8'h08;
  localparam logic [7:0] ADDR_CPU_SRC_STATE = 8'h0c;

  // reset values
  localparam logic [7:0] PROC_CLK_RST     = 8'h03;
  localparam logic [7:0] INT_OSC_MODE_RST = 8'h00;
  localparam logic [7:0] CPU_SRC_RST      = 8'h00;

  // field positions of the processor clock control register
  localparam int PCC_FRC_BIT  = 7;
  localparam int PCC_MCK_BIT  = 6;
  localparam int PCC_MFRC_BIT = 5;
  localparam int PCC_CLS_BIT  = 4;
  localparam int PCC_CK_MSB   = 3;
  // field positions of the two oscillator status/mode registers
  localparam int RCM_HALT_BIT = 0;
  localparam int CPU_CLOCK_SOURCE_STATE_FLAG_BIT = 0;

  // timing counts in CLK_I cycles (stabilization and multiplier lockup)
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] STAB_CYC_DEF = 16'h2000;
  localparam logic [CNT_W-1:0] LOCK_CYC_DEF = 16'h0800;
  // divider counter width, enough for divide by 64
  localparam int DIV_W = 5;
  localparam logic [3:0] DIV_SEL_RST = 4'h3;

  // standby mode requested by the power controller
  typedef enum logic [4:0] {
    CGS_MODE_RUN   = 5'b00001,
    CGS_MODE_HALT  = 5'b00010,
    CGS_MODE_LIGHT_IDLE_MODE = 5'b00100,
    CGS_MODE_DEEP_IDLE_MODE = 5'b01000,
    CGS_MODE_STOP  = 5'b10000
  } cgs_mode_t;

  // clock generator sequencing after reset
  typedef enum logic [1:0] {
    CGS_ST_STAB = 2'b01,
    CGS_ST_RUN  = 2'b10
  } cgs_state_t;

  // divider codes 0110 and 0111 are not valid clock selections
  function automatic logic cgs_ck_bad(input logic [3:0] ck);
    return ck[3:1] == 3'b011;
  endfunction

endpackage

// File: design/cgs_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
// divides fxx by 2..64 or follows the subclock; output flop only changes
// selection while low at a phase boundary, so no runt pulse escapes
module cgs_clk_div (
  input  wire logic       clk_i,      // fxx
  input  wire logic       rst_i,      // async reset, active high
  input  wire logic       run_i,      // internal system clock operable
  input  wire logic [3:0] sel_i,      // requested divider code
  input  wire logic       sub_lvl_i,  // synchronised subclock level
  output logic            clk_o,      // divided clock, registered
  output logic            on_sub_o    // active selection is subclock
);
  import cgs_pkg::*;

  logic [DIV_W-1:0] cnt_r;
  logic [3:0]       act_r;
  logic             out_r;

  // phase boundary for the active main-clock ratio
  wire [DIV_W:0]   lim_w  = (6'd1 << act_r[2:0]) - 6'd1;
  wire [DIV_W-1:0] lim    = lim_w[DIV_W-1:0];
  wire             at_edge = cnt_r == lim;
  // selection may swap only with the output low at a boundary
  wire swap_ok = !out_r && (act_r[3] ? !sub_lvl_i : at_edge);
  // low while stopped
  // a rise needs run; a fall always completes, so a stop never cuts a pulse
  wire out_nxt = act_r[3] ? (sub_lvl_i & (out_r | run_i))
                          : (at_edge ? (!out_r & run_i) : out_r);

  // divider state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      act_r <= DIV_SEL_RST;
      out_r <= 1'b0;
    end else begin
      cnt_r <= (at_edge || act_r[3]) ? '0 : cnt_r + 5'd1;
      if (swap_ok && sel_i != act_r) begin
        act_r <= sel_i;
      end
      out_r <= out_nxt;
    end
  end

  assign clk_o    = out_r;
  assign on_sub_o = act_r[3];

endmodule
`default_nettype wire

// File: testbench/cgs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cgs_top_tb_top;
  import cgs_pkg::*;
  logic       CLK_I, RST_I, WR_I, RD_I, WDT_OVF_I, OPT_INT_OSC_CTRL_I;
  logic       MULT_SEL_I, PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I, SUB_CLK_I;
  logic [7:0] ADDR_I, WDATA_I, RDATA_O;
  cgs_mode_t  MODE_I;
  logic       MAIN_OSC_RUN_O, MAIN_SYS_RUN_O, PERIPH_RUN_O, WDT_MAIN_RUN_O, WT_MAIN_RUN_O;
  logic       WT_SUB_RUN_O, SYS_CLK_RUN_O, CPU_CLK_RUN_O, PLL_RUN_O, PLL_STABLE_O, MULT_X4_O;
  logic       SUB_OSC_RUN_O, WDT_INT_RUN_O, INT_OSC_RUN_O, CPU_ON_INT_O, SYSTEM_CLOCK_OUTPUT_PIN_O;
  logic       SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O;
  logic [7:0] got;
  logic [7:0] sub_cnt;
  int         n_errors, n_checks;

  // short counts keep the stabilization and lockup phases a few cycles long
  cgs_top #(.STAB_CYC(16'h0010), .LOCK_CYC(16'h0008)) dut (
    .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
    .RD_I(RD_I), .RDATA_O(RDATA_O), .MODE_I(MODE_I), .WDT_OVF_I(WDT_OVF_I),
    .OPT_INT_OSC_CTRL_I(OPT_INT_OSC_CTRL_I), .MULT_SEL_I(MULT_SEL_I),
    .PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I(PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I), .SUB_CLK_I(SUB_CLK_I),
    .MAIN_OSC_RUN_O(MAIN_OSC_RUN_O), .MAIN_SYS_RUN_O(MAIN_SYS_RUN_O),
    .PERIPH_RUN_O(PERIPH_RUN_O), .WDT_MAIN_RUN_O(WDT_MAIN_RUN_O),
    .WT_MAIN_RUN_O(WT_MAIN_RUN_O), .WT_SUB_RUN_O(WT_SUB_RUN_O),
    .SYS_CLK_RUN_O(SYS_CLK_RUN_O), .CPU_CLK_RUN_O(CPU_CLK_RUN_O), .PLL_RUN_O(PLL_RUN_O),
    .PLL_STABLE_O(PLL_STABLE_O), .MULT_X4_O(MULT_X4_O), .SUB_OSC_RUN_O(SUB_OSC_RUN_O),
    .WDT_INT_RUN_O(WDT_INT_RUN_O), .INT_OSC_RUN_O(INT_OSC_RUN_O),
    .CPU_ON_INT_O(CPU_ON_INT_O), .SYSTEM_CLOCK_OUTPUT_PIN_O(SYSTEM_CLOCK_OUTPUT_PIN_O), .SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O(SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O));

  // 250 MHz main clock
  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end

  // slow subclock, 40 main cycles a period, unrelated to register traffic
  always @(posedge CLK_I) begin
    sub_cnt <= (sub_cnt == 8'h13) ? 8'h00 : sub_cnt + 8'h01;
    if (sub_cnt == 8'h13) SUB_CLK_I <= ~SUB_CLK_I;
  end

  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    @(posedge CLK_I);
    WR_I    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_I);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    @(posedge CLK_I);
    RD_I   <= 1'b0;
    #1;
    d = RDATA_O;
  endtask

  task automatic processor_clock_ctrl_reg(input logic [7:0] d);
    wr(ADDR_PROTECT, 8'ha5);
    wr(ADDR_PROC_CLK, d);
  endtask

  // bounded poll on the subclock status bit
  task automatic wait_cls(input logic v);
    int i;
    for (i = 0; i < 200; i++) begin
      rd(ADDR_PROC_CLK, got);
      if (got[PCC_CLS_BIT] === v) break;
    end
    if (i == 200) begin
      n_errors++;
      end_of_test();
    end
  endtask

  task automatic rises(input int n, output logic [7:0] r);
    logic prev;
    prev = SYSTEM_CLOCK_OUTPUT_PIN_O;
    r = 8'h00;
    repeat (n) begin
      cyc(1);
      if (SYSTEM_CLOCK_OUTPUT_PIN_O === 1'b1 && prev === 1'b0) r = r + 8'h01;
      prev = SYSTEM_CLOCK_OUTPUT_PIN_O;
    end
  endtask

  task automatic mode_chk(input cgs_mode_t m, input logic [7:0] e);
    @(posedge CLK_I);
    MODE_I <= m;
    cyc(4);
    chk8({MAIN_OSC_RUN_O, MAIN_SYS_RUN_O, PERIPH_RUN_O, WDT_MAIN_RUN_O, SYS_CLK_RUN_O,
          CPU_CLK_RUN_O, WT_MAIN_RUN_O, PLL_RUN_O}, e);
    chk8({SUB_OSC_RUN_O, WT_SUB_RUN_O, WDT_INT_RUN_O}, 8'h07);
  endtask

  task automatic do_reset();
    @(posedge CLK_I);
    RST_I <= 1'b1;
    cyc(1);
    chk8({SUB_OSC_RUN_O, WT_SUB_RUN_O, WDT_INT_RUN_O, SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O, SYSTEM_CLOCK_OUTPUT_PIN_O}, 8'h1a);
    repeat (19) @(posedge CLK_I);
    RST_I <= 1'b0;
  endtask

  // main sequence
  initial begin
    n_errors = 0; n_checks = 0; sub_cnt = 8'h00; SUB_CLK_I = 1'b0;
    RST_I = 1'b1; WR_I = 1'b0; RD_I = 1'b0; ADDR_I = 8'h00; WDATA_I = 8'h00;
    MODE_I = CGS_MODE_RUN; WDT_OVF_I = 1'b0; OPT_INT_OSC_CTRL_I = 1'b0;
    MULT_SEL_I = 1'b0; PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I = 1'b0;
    do_reset();
    // stabilization: of the main clocks only the oscillator runs, multiplier starts halfway
    cyc(3);
    chk8({MAIN_OSC_RUN_O, MAIN_SYS_RUN_O, SYS_CLK_RUN_O, WT_MAIN_RUN_O, PLL_RUN_O}, 8'h10);
    cyc(9);
    chk8({PLL_RUN_O, PLL_STABLE_O, SYS_CLK_RUN_O}, 8'h04);
    cyc(30);
    chk1(PLL_STABLE_O, 1'b1);
    rd(ADDR_INT_OSC_MODE, got); chk8(got, 8'h00);
    rd(ADDR_CPU_SRC_STATE, got); chk8(got, 8'h00);
    rd(ADDR_PROC_CLK, got); chk8(got, PROC_CLK_RST);
    wr(ADDR_CPU_SRC_STATE, 8'hff); rd(ADDR_CPU_SRC_STATE, got); chk8(got, 8'h00);
    rd(8'h40, got); chk8(got, 8'h00);
    chk1(CPU_ON_INT_O, 1'b0);
    // standby modes from normal run
    mode_chk(CGS_MODE_RUN, 8'hff);
    mode_chk(CGS_MODE_HALT, 8'hfb);
    mode_chk(CGS_MODE_LIGHT_IDLE_MODE, 8'h83);
    mode_chk(CGS_MODE_DEEP_IDLE_MODE, 8'h82);
    mode_chk(CGS_MODE_STOP, 8'h00);
    mode_chk(CGS_MODE_RUN, 8'hff);
    // multiplier select after lock is regained
    MULT_SEL_I <= 1'b1; cyc(40); chk1(MULT_X4_O, 1'b1);
    MULT_SEL_I <= 1'b0; cyc(3); chk1(MULT_X4_O, 1'b0);
    // halt bit honoured only with the option set
    wr(ADDR_INT_OSC_MODE, 8'h01); cyc(3); chk1(INT_OSC_RUN_O, 1'b1);
    OPT_INT_OSC_CTRL_I <= 1'b1; cyc(3); chk1(INT_OSC_RUN_O, 1'b0);
    rd(ADDR_INT_OSC_MODE, got); chk8(got, 8'h01);
    wr(ADDR_INT_OSC_MODE, 8'h00); cyc(3); chk1(INT_OSC_RUN_O, 1'b1);
    // protected write: bare, disarmed and accepted cases
    wr(ADDR_PROC_CLK, 8'h01); rd(ADDR_PROC_CLK, got); chk8(got, 8'h03);
    wr(ADDR_PROTECT, 8'h00); wr(ADDR_INT_OSC_MODE, 8'h00); wr(ADDR_PROC_CLK, 8'h01);
    rd(ADDR_PROC_CLK, got); chk8(got, 8'h03);
    processor_clock_ctrl_reg(8'h01); rd(ADDR_PROC_CLK, got); chk8(got, 8'h01);
    processor_clock_ctrl_reg(8'h06); rd(ADDR_PROC_CLK, got); chk8(got, 8'h01);
    // clock pin only once the port selects it, rate set by the divider code
    cyc(3); chk1(SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O, 1'b1);
    PORT_SYSTEM_CLOCK_OUTPUT_PIN_SEL_I <= 1'b1; cyc(3); chk1(SYSTEM_CLOCK_OUTPUT_PIN_OE_N_O, 1'b0);
    cyc(20); rises(64, got); chk8(got, 8'h10);
    processor_clock_ctrl_reg(8'h00); cyc(20); rises(64, got); chk8(got, 8'h20);
    processor_clock_ctrl_reg(8'h02); cyc(20); rises(64, got); chk8(got, 8'h08);
    MODE_I <= CGS_MODE_LIGHT_IDLE_MODE; cyc(40); rises(64, got);
    chk8({got[6:0], SYSTEM_CLOCK_OUTPUT_PIN_O}, 8'h00);
    MODE_I <= CGS_MODE_RUN;
    // main oscillator stop waits for the subclock, then switch back
    // no dma traffic around switch
    processor_clock_ctrl_reg(8'h41); cyc(5); chk1(MAIN_OSC_RUN_O, 1'b1);
    processor_clock_ctrl_reg(8'h49); wait_cls(1'b1); cyc(4);
    chk8({MAIN_OSC_RUN_O, MAIN_SYS_RUN_O, SYS_CLK_RUN_O, CPU_CLK_RUN_O}, 8'h03);
    processor_clock_ctrl_reg(8'h09); cyc(20); chk1(MAIN_OSC_RUN_O, 1'b1);
    processor_clock_ctrl_reg(8'h01); wait_cls(1'b0);
    cyc(4); chk1(MAIN_SYS_RUN_O, 1'b1);
    // watchdog overflow in stabilization moves the CPU to the internal osc
    do_reset();
    cyc(4); WDT_OVF_I <= 1'b1; cyc(1); WDT_OVF_I <= 1'b0; cyc(30);
    rd(ADDR_CPU_SRC_STATE, got); chk8(got, 8'h01);
    chk1(CPU_ON_INT_O, 1'b1);
    wr(ADDR_INT_OSC_MODE, 8'h01); cyc(3); chk1(INT_OSC_RUN_O, 1'b1);
    rd(ADDR_INT_OSC_MODE, got); chk8(got, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
